// file: phantom_rtc.sv
// Purpose: timekeeper unlocked by a serial key on SRAM bus cycles
// Assumes: pins asynchronous to core_clk, cycles far longer than 5 ns
// Notes:   Wishbone slave gives status and a live view of the time
//
// Design decisions made here: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "phantom_rtc_cfg.svh"
module phantom_rtc
    import phantom_rtc_pkg::*;
#(
    parameter int TICK_CYCLES = `HUNDREDTH_NS / `CLK_PERIOD_NS
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic        abort_n,
    input  wire logic        serial_data_line_in,
    output logic             serial_data_line_out,
    output logic             serial_data_line_oe_n,
    output logic             mem_inhibit,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o
);
    // ************************************************
    // reset release and pin synchronisers
    // ************************************************
    logic [1:0] rsync;
    logic       rst_core_n;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rsync <= 2'h0;
        end else begin
            rsync <= {rsync[0], 1'h1};
        end
    end
    assign rst_core_n = rsync[1];

    logic [4:0] pins_s;
    logic       ce_s;
    logic       oe_s;
    logic       we_s;
    logic       ab_s;
    logic       dq_s;

    pin_sync #(
        .W       (5),
        .RST_VAL (5'h1F)
    ) u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_core_n),
        .din      ({ce_n, oe_n, we_n, abort_n, serial_data_line_in}),
        .dout     (pins_s)
    );
    assign {ce_s, oe_s, we_s, ab_s, dq_s} = pins_s;

    // ************************************************
    // byte FIFO between the serial engine and the registers
    // ************************************************
    fifo_if #(.W(`FIFO_WIDTH)) fin ();
    fifo_if #(.W(`FIFO_WIDTH)) fout ();

    byte_fifo #(
        .WIDTH (`FIFO_WIDTH),
        .DEPTH (`FIFO_DEPTH)
    ) u_fifo (
        .core_clk (core_clk),
        .rst_n    (rst_core_n),
        .wr       (fin),
        .rd       (fout)
    );

    // ************************************************
    // state
    // ************************************************
    localparam logic [63:0] KEY     = `KEY_PATTERN;
    localparam logic [63:0] TK_MASK = `TK_MASK;
    localparam logic [20:0] TICK_LAST = 21'(TICK_CYCLES - 1);

    core_state_t s;
    core_state_t n;
    logic        tick_now;

    assign tick_now   = (s.div == TICK_LAST);
    assign fin.valid  = s.push_v;
    assign fin.data   = s.push_d;
    // a hundredths update owns the registers this cycle
    assign fout.ready = !tick_now;

    always_comb begin
        logic [7:0][7:0] r;
        logic [7:0]      hf;
        logic            carry;
        logic            rd_act;
        logic            wr_act;
        logic            rd_start;
        logic            rd_end;
        logic            wr_end;
        logic            advance;
        logic            abort;
        logic [2:0]      idx;
        r        = s.regs;
        hf       = `BCD_ZERO;
        carry    = 1'b0;
        rd_act   = 1'b0;
        wr_act   = 1'b0;
        abort    = 1'b0;
        rd_start = 1'b0;
        rd_end   = 1'b0;
        wr_end   = 1'b0;
        advance  = 1'b0;
        idx      = fout.data[10:8];
        n        = s;

        // ************************************************
        // timekeeping
        // ************************************************
        n.div = tick_now ? 21'h0 : s.div + 21'h1;
        carry = tick_now && !s.regs[`REG_DAY][`DAY_OSC_BIT]; // see R8
        if (carry) begin // see R16
            carry = (r[0] == `BCD_HUND_MAX);
            r[0]  = carry ? `BCD_ZERO : bcd_inc(r[0]);
        end
        if (carry) begin
            carry = (r[1] == `BCD_MIN_MAX);
            r[1]  = carry ? `BCD_ZERO : bcd_inc(r[1]);
        end
        if (carry) begin
            carry = (r[2] == `BCD_MIN_MAX);
            r[2]  = carry ? `BCD_ZERO : bcd_inc(r[2]);
        end
        if (carry) begin
            if (r[`REG_HOURS][`HR_MODE_BIT]) begin // see R3
                hf    = {3'h0, r[`REG_HOURS][4:0]};
                carry = 1'b0;
                if (hf == `BCD_H12_MAX) begin
                    hf = `BCD_ONE;
                end else if (hf == `BCD_H12_PRE) begin
                    // 11 -> 12 flips the half of the day
                    carry = r[`REG_HOURS][`HR_PM_BIT]; // see R4
                    r[`REG_HOURS][`HR_PM_BIT] = !r[`REG_HOURS][`HR_PM_BIT]; // see R4
                    hf = `BCD_H12_MAX;
                end else begin
                    hf = bcd_inc(hf);
                end
                r[`REG_HOURS][4:0] = hf[4:0];
            end else begin
                hf    = {2'h0, r[`REG_HOURS][5:0]}; // see R5
                carry = (hf == `BCD_H24_MAX);
                hf    = carry ? `BCD_ZERO : bcd_inc(hf);
                r[`REG_HOURS][5:0] = hf[5:0]; // see R5
            end
        end
        if (carry) begin
            r[`REG_DAY][2:0] = (r[`REG_DAY][2:0] == `DOW_LAST) ? `DOW_FIRST
                                                                : r[`REG_DAY][2:0] + 3'h1;
            carry = (r[5] == days_in_month(r[6], r[7]));
            r[5]  = carry ? `BCD_ONE : bcd_inc(r[5]);
        end
        if (carry) begin
            carry = (r[6] == `BCD_MON_MAX);
            r[6]  = carry ? `BCD_ONE : bcd_inc(r[6]);
        end
        if (carry) begin
            r[7] = (r[7] == `BCD_HUND_MAX) ? `BCD_ZERO : bcd_inc(r[7]);
        end

        // completed bytes land here, unused bits forced low
        if (fout.valid && fout.ready) begin
            r[idx] = fout.data[7:0] & TK_MASK[idx*8 +: 8]; // see R10 see R11
        end
        n.regs = r;

        // ************************************************
        // pin cycle detection
        // ************************************************
        rd_act = !ce_s && !oe_s && we_s && s.pin_en;
        wr_act = !ce_s && !we_s && s.pin_en;
        if (s.push_v && fin.ready) begin
            n.push_v = 1'b0;
        end
        // a pending byte holds every edge until the FIFO takes it
        if (!s.push_v) begin
            n.rd_prev = rd_act;
            n.wr_prev = wr_act;
            if (wr_act) begin
                n.dq_hold = dq_s;
            end
            rd_start = rd_act && !s.rd_prev;
            rd_end   = !rd_act && s.rd_prev;
            wr_end   = !wr_act && s.wr_prev;
        end

        abort = (s.phase == PH_XFER) && !ab_s
                && !s.regs[`REG_DAY][`DAY_ABORT_BIT]; // see R6 see R7

        // ************************************************
        // key match and bit transfer
        // ************************************************
        if (abort) begin
            // registers untouched, partial byte dropped
            n.phase       = PH_MATCH; // see R7
            n.ptr         = 6'h0;
            n.failed      = 1'b1;
            n.dq_oe_n     = 1'b1;
            n.mem_inhibit = 1'b0;
        end else begin
            unique case (s.phase)
                PH_MATCH: begin
                    if (rd_start) begin
                        n.ptr    = 6'h0; // see R12
                        n.failed = 1'b0; // see R12
                    end else if (wr_end && !s.failed) begin
                        if (s.dq_hold == KEY[s.ptr]) begin // see R1 see R2
                            if (s.ptr == `PTR_LAST) begin
                                n.phase       = PH_XFER; // see R14
                                n.cnt         = 6'h0;
                                n.mem_inhibit = 1'b1; // see R14
                            end else begin
                                n.ptr = s.ptr + 6'h1;
                            end
                        end else begin
                            n.failed = 1'b1; // see R13
                        end
                    end
                end
                PH_XFER: begin
                    if (rd_start) begin
                        n.dq_out  = s.regs[s.cnt[5:3]][s.cnt[2:0]]; // see R15
                        n.dq_oe_n = 1'b0;
                    end
                    if (rd_end) begin
                        n.dq_oe_n = 1'b1;
                        advance   = 1'b1;
                    end
                    if (wr_end) begin
                        n.shift[s.cnt[2:0]] = s.dq_hold;
                        if (s.cnt[2:0] == `BIT_LAST) begin
                            // whole bytes only, see R15
                            n.push_v = 1'b1;
                            n.push_d = {s.cnt[5:3], s.dq_hold, s.shift[6:0]};
                        end
                        advance = 1'b1;
                    end
                    if (advance) begin
                        if (s.cnt == `PTR_LAST) begin
                            n.phase       = PH_MATCH; // see R14
                            n.ptr         = 6'h0;
                            n.failed      = 1'b1;
                            n.mem_inhibit = 1'b0;
                        end else begin
                            n.cnt = s.cnt + 6'h1; // see R15
                        end
                    end
                end
            endcase
        end

        // ************************************************
        // Wishbone slave
        // ************************************************
        n.ack = wb_cyc_i && wb_stb_i && !s.ack;
        if (n.ack) begin
            if (wb_we_i && wb_sel_i[0] && wb_adr_i == `WB_CTRL) begin
                n.pin_en = wb_dat_i[0];
            end
            case (wb_adr_i)
                `WB_CTRL:    n.wb_dat = {31'h0, s.pin_en};
                `WB_STATUS:  n.wb_dat = {10'h0, s.cnt, 2'h0, s.ptr, 4'h0,
                                         s.regs[`REG_HOURS][`HR_MODE_BIT],
                                         s.regs[`REG_DAY][`DAY_OSC_BIT],
                                         s.failed, s.phase == PH_XFER};
                `WB_TIME_LO: n.wb_dat = s.regs[3:0];
                `WB_TIME_HI: n.wb_dat = s.regs[7:4];
                default:     n.wb_dat = 32'h0;
            endcase
        end else begin
            n.wb_dat = 32'h0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            s         <= '0;
            s.phase   <= PH_MATCH;
            s.failed  <= 1'b1;
            s.dq_oe_n <= 1'b1;
            s.regs    <= `TK_RESET; // see R9
            s.pin_en  <= `CTRL_RESET;
        end else begin
            s <= n;
        end
    end

    assign serial_data_line_out  = s.dq_out;
    assign serial_data_line_oe_n = s.dq_oe_n;
    assign mem_inhibit           = s.mem_inhibit;
    assign wb_dat_o              = s.wb_dat;
    assign wb_ack_o              = s.ack;
endmodule : phantom_rtc
`default_nettype wire

// file: phantom_rtc_cfg.svh
// Purpose: constants of the serial-access timekeeper
// Assumes: core_clk at 200 MHz
// Notes:   included by the package and by the top module
//
// Summary of operation
// R1: unlock key is bytes C5 3A A3 5C sent twice, 64 bits.
// R2: each key byte goes least significant bit first, one bit per write.
// R3: hours bit 7 high selects 12-hour mode, low selects 24-hour mode.
// R4: in 12-hour mode hours bit 5 high means PM, low means AM.
// R5: in 24-hour mode hours bit 5 is the second tens-of-hours bit.
// R6: day bit 4 high makes the device ignore the abort pin.
// R7: day bit 4 low lets a low abort pin end a transfer, data kept.
// R8: day bit 5 high stops the oscillator, low lets time advance.
// R9: oscillator-stop and abort-ignore bits are one out of reset.
// R10: unused bits of registers 1 to 6 always read as zero.
// R11: writes to always-zero bits are accepted and change nothing.
// R12: a read during matching restarts the key pointer; host unlocks after a read.
// R13: a write bit mismatch freezes the pointer; later writes are ignored.
// R14: after 64 matches the next 64 cycles move clock bits; memory blocked.
// R15: transfer walks bit 0 of register 0 to bit 7 of register 7.
// R16: running oscillator advances BCD time and date with month and leap handling.
`ifndef PHANTOM_RTC_CFG_SVH
`define PHANTOM_RTC_CFG_SVH

`define KEY_PATTERN     64'h5CA33AC55CA33AC5
`define PTR_LAST        6'h3F
`define BIT_LAST        3'h7
`define HUNDREDTH_NS    10000000
`define CLK_PERIOD_NS   5
`define REG_HOURS       3'h3
`define REG_DAY         3'h4
`define HR_MODE_BIT     7
`define HR_PM_BIT       5
`define DAY_ABORT_BIT   4
`define DAY_OSC_BIT     5
`define TK_MASK         64'hFF1F3F37BF7F7FFF
`define TK_RESET        64'h0001013100000000
`define BCD_HUND_MAX    8'h99
`define BCD_MIN_MAX     8'h59
`define BCD_H24_MAX     8'h23
`define BCD_H12_MAX     8'h12
`define BCD_H12_PRE     8'h11
`define BCD_MON_MAX     8'h12
`define BCD_ONE         8'h01
`define BCD_ZERO        8'h00
`define DOW_LAST        3'h7
`define DOW_FIRST       3'h1
`define WB_CTRL         8'h00
`define WB_STATUS       8'h04
`define WB_TIME_LO      8'h08
`define WB_TIME_HI      8'h0C
`define CTRL_RESET      1'h1
`define FIFO_DEPTH      16
`define FIFO_WIDTH      11

`endif

// file: phantom_rtc_pkg.sv
// Purpose: types and BCD helpers of the serial-access timekeeper
// Assumes: phantom_rtc_cfg.svh
// Notes:   none
package phantom_rtc_pkg;
    `include "phantom_rtc_cfg.svh"

    typedef enum logic {
        PH_MATCH = 1'b0,
        PH_XFER  = 1'b1
    } phase_t;

    typedef struct packed {
        phase_t          phase;
        logic [5:0]      ptr;
        logic            failed;
        logic [5:0]      cnt;
        logic [7:0]      shift;
        logic            dq_hold;
        logic            rd_prev;
        logic            wr_prev;
        logic            dq_out;
        logic            dq_oe_n;
        logic            mem_inhibit;
        logic            push_v;
        logic [10:0]     push_d;
        logic [20:0]     div;
        logic [7:0][7:0] regs;
        logic            pin_en;
        logic            ack;
        logic [31:0]     wb_dat;
    } core_state_t;

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            return {v[7:4] + 4'h1, 4'h0};
        end
        return {v[7:4], v[3:0] + 4'h1};
    endfunction : bcd_inc

    // leap test on BCD year, good through 2099
    function automatic logic [7:0] days_in_month(input logic [7:0] m, input logic [7:0] y);
        logic leap;
        leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                    : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
        case (m)
            8'h02:                      return leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
            default:                    return 8'h31;
        endcase
    endfunction : days_in_month
endpackage : phantom_rtc_pkg

// file: fifo_if.sv
// Purpose: valid/ready carrier between the engine and its FIFO
// Assumes: one clock
// Notes:   none
`timescale 1ns/1ps
`default_nettype none
interface fifo_if #(parameter int W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : fifo_if
`default_nettype wire

// file: pin_sync.sv
// Purpose: two-flop synchroniser for asynchronous pins
// Assumes: rst_n already synchronous to core_clk on release
// Notes:   first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int             W       = 1,
    parameter logic [W-1:0]   RST_VAL = '1
) (
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_state_t;

    sync_state_t s;
    sync_state_t n;

    always_comb begin
        n    = s;
        n.s1 = din;
        n.s2 = s.s1;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= {RST_VAL, RST_VAL};
        end else begin
            s <= n;
        end
    end

    assign dout = s.s2;
endmodule : pin_sync
`default_nettype wire

// file: byte_fifo.sv
// Purpose: small synchronous FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   read data comes from the storage register
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic core_clk,
    input  wire logic rst_n,
    fifo_if.snk       wr,
    fifo_if.src       rd
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } fifo_state_t;

    fifo_state_t s;
    fifo_state_t n;
    logic        do_wr;
    logic        do_rd;

    assign wr.ready = (s.cnt != (AW+1)'(DEPTH));
    assign rd.valid = (s.cnt != '0);
    assign rd.data  = s.mem[s.rp];
    assign do_wr    = wr.valid && wr.ready;
    assign do_rd    = rd.valid && rd.ready;

    always_comb begin
        n = s;
        if (do_wr) begin
            n.mem[s.wp] = wr.data;
            n.wp        = s.wp + 1'b1;
        end
        if (do_rd) begin
            n.rp = s.rp + 1'b1;
        end
        case ({do_wr, do_rd})
            2'h2:    n.cnt = s.cnt + 1'b1;
            2'h1:    n.cnt = s.cnt - 1'b1;
            default: n.cnt = s.cnt;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end
endmodule : byte_fifo
`default_nettype wire

// file: phantom_rtc_chk.sv
// Purpose: port checks of the phantom timekeeper
// Assumes: bound to phantom_rtc, pins driven on core_clk edges
// Notes:   sync delay of the pins taken as three edges
`timescale 1ns/1ps
`default_nettype none
module phantom_rtc_chk (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        ce_n,
    input wire logic        oe_n,
    input wire logic        we_n,
    input wire logic        serial_data_line_out,
    input wire logic        serial_data_line_oe_n,
    input wire logic        mem_inhibit,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o
);
    // ********
    // cycle ends counted while transfer runs
    // ********
    logic       act_q;
    logic [6:0] ends;
    wire logic  act = !ce_n && (!we_n || !oe_n);
    wire logic  rd  = !ce_n && !oe_n && we_n;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            act_q <= 1'b0;
            ends  <= 7'h00;
        end else begin
            act_q <= act;
            ends  <= !mem_inhibit ? 7'h00 : ends + {6'h00, act_q && !act};
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    a_drive_in_read: assert property (!serial_data_line_oe_n |-> $past(rd, 3) || $past(rd, 4))
        else $error("line driven outside a read");
    a_drive_in_xfer: assert property (!serial_data_line_oe_n |-> mem_inhibit)
        else $error("line driven outside transfer");
    a_inhibit_rise: assert property ($rose(mem_inhibit) |-> $past(we_n, 2) && !$past(we_n, 5))
        else $error("transfer opened without a write");
    a_xfer_count: assert property (ends <= 7'h40)
        else $error("transfer longer than 64 cycles");
    a_bit_stable: assert property (!serial_data_line_oe_n && !$past(serial_data_line_oe_n)
        |-> $stable(serial_data_line_out))
        else $error("bit changed inside a read");
endmodule : phantom_rtc_chk
bind phantom_rtc phantom_rtc_chk u_chk (.*);
`default_nettype wire

// file: sram_host.sv
// Purpose: host issuing SRAM cycles to the timekeeper
// Assumes: phases of six core cycles
// Notes:   released line shows inverse of last value
`timescale 1ns/1ps
`default_nettype none
module sram_host (
    input  wire logic core_clk,
    output logic      ce_n,
    output logic      oe_n,
    output logic      we_n,
    output logic      line_in,
    input  wire logic line_out,
    input  wire logic line_oe_n
);
    // ********
    // pin cycles
    // ********
    localparam logic [7:0] KEY_BYTE [4] = '{8'hC5, 8'h3A, 8'hA3, 8'h5C};
    logic d = 1'b0;
    initial begin
        ce_n = 1'b1;
        oe_n = 1'b1;
        we_n = 1'b1;
    end
    assign line_in = line_oe_n ? d : line_out;
    task automatic cyc(input logic wr, input logic b, output logic r);
        @(posedge core_clk);
        ce_n <= 1'b0;
        oe_n <= wr;
        we_n <= !wr;
        d    <= wr ? b : !d;
        repeat (6) @(posedge core_clk);
        r = line_in;
        ce_n <= 1'b1;
        oe_n <= 1'b1;
        we_n <= 1'b1;
        d    <= !d;
        repeat (5) @(posedge core_clk);
    endtask : cyc
    task automatic unlock(input logic first_read, input int n, input int flip);
        logic r;
        if (first_read) cyc(1'b0, 1'b0, r);
        for (int i = 0; i < n; i++) begin
            cyc(1'b1, KEY_BYTE[(i / 8) % 4][i % 8] ^ (i == flip), r);
        end
    endtask : unlock
    // any bit range lo to hi-1 in order, bit 0 of register 0 is index 0
    task automatic xfer(input logic wr, input int lo, input int hi, inout logic [63:0] v);
        logic r;
        for (int k = lo; k < hi; k++) begin
            cyc(wr, v[k], r);
            v[k] = wr ? v[k] : r;
        end
    endtask : xfer
endmodule : sram_host
`default_nettype wire

// file: phantom_rtc_tb_top.sv
// Purpose: self-checking bench of the phantom timekeeper
// Assumes: sram_host drives the SRAM pins, abort_n and Wishbone driven here
// Notes:   tick shortened to 20 cycles
`timescale 1ns/1ps
`default_nettype none
`include "phantom_rtc_cfg.svh"
module phantom_rtc_tb_top;
    // ********
    // bench
    // ********
    logic        core_clk = 1'b0;
    logic        rst_n    = 1'b0;
    logic        abort_n  = 1'b1;
    logic        cyc      = 1'b0;
    logic        stb      = 1'b0;
    logic        we       = 1'b0;
    logic [7:0]  adr      = 8'h00;
    logic [31:0] wdat     = 32'h0;
    logic [31:0] seed     = 32'h0000962B;
    logic        ce_n, oe_n, we_n, sdl_in, sdl_out, sdl_oe_n, mem_inhibit, ack;
    logic [31:0] dat_o, rdat;
    logic [63:0] v, e, got;
    int          fail_count = 0;
    int          n_checks   = 0;
    int          ticks      = 0;
    always #2.5 core_clk = ~core_clk;
    phantom_rtc #(.TICK_CYCLES(20)) u_dut (.core_clk(core_clk), .rst_n(rst_n), .ce_n(ce_n), .oe_n(oe_n),
        .we_n(we_n), .abort_n(abort_n), .serial_data_line_in(sdl_in), .serial_data_line_out(sdl_out),
        .serial_data_line_oe_n(sdl_oe_n), .mem_inhibit(mem_inhibit), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack));
    sram_host u_host (.core_clk(core_clk), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .line_in(sdl_in),
        .line_out(sdl_out), .line_oe_n(sdl_oe_n));
    function automatic logic [31:0] rnd(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : rnd
    function automatic logic [7:0] bcd15(input logic [7:0] b);
        int n;
        n = (b[7:4] * 10 + b[3:0] + 15) % 100;
        return {4'(n / 10), 4'(n % 10)};
    endfunction : bcd15
    task automatic chk(input string n, input logic [63:0] exp, input logic [63:0] seen);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge core_clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do begin
            @(posedge core_clk);
            t++;
        end while (ack !== 1'b1 && t < 20);
        rdat = dat_o;
        chk("wb_ack", 64'h1, 64'(ack));
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge core_clk);
    endtask : wb
    task automatic rd_time(output logic [63:0] t);
        wb(1'b0, `WB_TIME_LO, 32'h0);
        t[31:0] = rdat;
        wb(1'b0, `WB_TIME_HI, 32'h0);
        t[63:32] = rdat;
    endtask : rd_time
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude
    always @(posedge core_clk) begin
        ticks <= ticks + 1;
        if (ticks == 40000) begin
            fail_count++;
            conclude();
        end
    end
    initial begin
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        rd_time(got);
        chk("time_reset", `TK_RESET, got);
        wb(1'b0, 8'h20, 32'h0);
        chk("unmapped", 64'h0, 64'(rdat));
        wb(1'b1, `WB_CTRL, 32'h0);
        wb(1'b0, `WB_CTRL, 32'h0);
        chk("ctrl_off", 64'h0, 64'(rdat[0]));
        u_host.unlock(1'b1, 64, -1);
        chk("pins_off", 64'h0, 64'(mem_inhibit));
        wb(1'b1, `WB_CTRL, 32'h1);
        u_host.unlock(1'b1, 64, 10);
        u_host.unlock(1'b0, 64, -1);
        chk("bad_key", 64'h0, 64'(mem_inhibit));
        u_host.unlock(1'b1, 20, -1);
        u_host.unlock(1'b1, 64, -1);
        chk("key_restart", 64'h1, 64'(mem_inhibit));
        for (int i = 0; i < 8; i++) begin
            seed = rnd(seed);
            v[i*8 +: 8] = seed[7:0];
        end
        v[31] = 1'b1;
        v[37:36] = 2'b11;
        u_host.xfer(1'b1, 0, 64, v);
        e = v & `TK_MASK;
        rd_time(got);
        chk("time_a", e, got);
        wb(1'b0, `WB_STATUS, 32'h0);
        chk("status_a", 64'hE, 64'(rdat[3:0]));
        u_host.unlock(1'b1, 64, -1);
        u_host.xfer(1'b0, 0, 5, got);
        abort_n <= 1'b0;
        repeat (10) @(posedge core_clk);
        chk("abort_ignored", 64'h1, 64'(mem_inhibit));
        abort_n <= 1'b1;
        u_host.xfer(1'b0, 5, 64, got);
        chk("serial_read", e, got);
        chk("xfer_closed", 64'h0, 64'(mem_inhibit));
        v = 64'h2412312123595890;
        u_host.unlock(1'b1, 64, -1);
        u_host.xfer(1'b1, 0, 64, v);
        repeat (500) @(posedge core_clk);
        rd_time(got);
        chk("time_stopped", v, got);
        e = ~v;
        u_host.unlock(1'b1, 64, -1);
        u_host.xfer(1'b1, 0, 4, e);
        abort_n <= 1'b0;
        repeat (10) @(posedge core_clk);
        chk("abort_taken", 64'h0, 64'(mem_inhibit));
        abort_n <= 1'b1;
        rd_time(got);
        chk("time_kept", v, got);
        v[39:32] = 8'h01;
        v[7:0] = 8'h00;
        u_host.unlock(1'b1, 64, -1);
        u_host.xfer(1'b1, 0, 64, v);
        rd_time(e);
        repeat (292) @(posedge core_clk);
        rd_time(got);
        chk("hundredths_run", 64'(bcd15(e[7:0])), 64'(got[7:0]));
        conclude();
    end
endmodule : phantom_rtc_tb_top
`default_nettype wire
